// ---- hw/adcr_pkg.sv ----
// constants and types for the converter control and result registers
// Functional notes
// - one shared converter, 10-bit unsigned result
// - bandgap and line amplifier offered as sources
// - source field plus channel field pick input
// - align 0: high D9..D2, low D1..D0 top
// - align 1: high D9..D8 low, low D7..D0
// - unused result bit positions read zero
// - converter disabled keeps result registers unchanged
// - result pair read-only, readable after conversion
// - two 8-bit control registers, busy readable
// - 4-bit channel field selects external channel
// - 3-bit source field picks internal or external
// - analog pin loses its digital function
// - analog pin has pull-high removed automatically
// - start 0-1-0 launches, busy, done flag
// - source codes: ext, bandgap, line amp, ground
// - converter clock is system clock divided 1..128
// - channel codes 0-3 valid, others float
package adcr_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h00;
   localparam logic [7:0] ADDR_RESULT_LOW  = 8'h04;
   localparam logic [7:0] ADDR_CONTROL_0   = 8'h08;
   localparam logic [7:0] ADDR_CONTROL_1   = 8'h0c;
   localparam logic [7:0] ADDR_PIN_FUNC    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h18;

   // conv_control_0 fields
   localparam int C0_START_BIT = 7;
   localparam int C0_BUSY_BIT  = 6;
   localparam int C0_EN_BIT    = 5;
   localparam int C0_ALIGN_BIT = 4;
   localparam int C0_CH_LSB    = 0;

   // conv_control_1 fields
   localparam int C1_SRC_LSB  = 5;
   localparam int C1_VREF_LSB = 3;
   localparam int C1_DIV_LSB  = 0;

   // widths
   localparam int RESULT_W = 10;
   localparam int CH_W     = 4;
   localparam int NUM_EXT  = 4;

   // reset values
   localparam logic [7:0] CONTROL_0_RST = 8'h00;
   localparam logic [7:0] CONTROL_1_RST = 8'h00;
   localparam logic [3:0] PIN_FUNC_RST  = 4'h0;
   localparam logic [9:0] RESULT_RST    = 10'h000;

   // converter clock divider: counter width covers divide by 128
   localparam int          DIV_CNT_W  = 7;
   localparam int unsigned SYS_CLK_NS = 100;

   // analog source routed to the converter
   typedef enum logic [1:0] {
      SRC_EXTERNAL = 2'b00,
      SRC_BANDGAP  = 2'b01,
      SRC_LINE_AMP = 2'b10,
      SRC_GROUND   = 2'b11
   } adcr_src_e;

   // successive approximation sequencer
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TRIAL = 2'b01,
      ST_DONE  = 2'b10
   } adcr_state_e;

endpackage

// ---- hw/adcr_top.sv ----
// converter control, result registers, apb slave and interrupt
`timescale 1ns/1ns
module adcr_top
   import adcr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                comp_hi,
   output logic [RESULT_W-1:0]      sar_code,
   output logic                     sar_sample,
   output logic                     conv_power_on,
   output logic [1:0]               mux_source,
   output logic [1:0]               mux_ext_ch,
   output logic                     mux_ext_valid,
   output logic [1:0]               vref_sel,
   output logic [NUM_EXT-1:0]       pin_digital_off,
   output logic [NUM_EXT-1:0]       pin_pullup_off,
   output logic                     irq
);

   // ---------------- functions ----------------
   // source field to routed source
   function automatic adcr_src_e src_decode(input logic [2:0] code);
      unique case (code)
         3'h1:        src_decode = SRC_BANDGAP;
         3'h2:        src_decode = SRC_LINE_AMP;
         3'h3, 3'h4:  src_decode = SRC_GROUND;
         default:     src_decode = SRC_EXTERNAL;
      endcase
   endfunction

   // divider terminal count for a 1,2,4..128 ratio
   function automatic logic [DIV_CNT_W-1:0] div_limit(input logic [2:0] sel);
      logic [7:0] ratio;
      ratio     = 8'h01 << sel;
      div_limit = DIV_CNT_W'(ratio - 8'h01);
   endfunction

   // ---------------- registers ----------------
   logic [7:0]          control_0_r;
   logic [7:0]          control_1_r;
   logic [NUM_EXT-1:0]  pin_func_r;
   logic [RESULT_W-1:0] result_r;
   logic                start_prev_r;
   logic                busy_r;
   logic                done_stat_r;
   logic                done_mask_r;
   adcr_state_e         state_r;
   logic [3:0]          bit_idx_r;
   logic [RESULT_W-1:0] code_r;
   logic [DIV_CNT_W-1:0] div_cnt_r;
   logic                sample_r;

   // ---------------- field views ----------------
   wire logic       conv_en   = control_0_r[C0_EN_BIT];
   wire logic       align     = control_0_r[C0_ALIGN_BIT];
   wire logic       start_bit = control_0_r[C0_START_BIT];
   wire logic [3:0] ch_sel    = control_0_r[C0_CH_LSB +: CH_W];
   wire logic [2:0] src_sel   = control_1_r[C1_SRC_LSB +: 3];
   wire logic [1:0] vref_fld  = control_1_r[C1_VREF_LSB +: 2];
   wire logic [2:0] div_sel   = control_1_r[C1_DIV_LSB +: 3];

   // ---------------- bus decode ----------------
   wire logic setup_ph  = psel & ~penable;
   wire logic wr_take   = psel & penable & pready & pwrite;
   wire logic [7:0] a8  = 8'(paddr);
   wire logic hit_rh    = (a8 == ADDR_RESULT_HIGH);
   wire logic hit_rl    = (a8 == ADDR_RESULT_LOW);
   wire logic hit_c0    = (a8 == ADDR_CONTROL_0);
   wire logic hit_c1    = (a8 == ADDR_CONTROL_1);
   wire logic hit_pf    = (a8 == ADDR_PIN_FUNC);
   wire logic hit_st    = (a8 == ADDR_IRQ_STATUS);
   wire logic hit_mk    = (a8 == ADDR_IRQ_MASK);
   wire logic hit_any   = hit_rh | hit_rl | hit_c0 | hit_c1 | hit_pf | hit_st | hit_mk;
   // result registers refuse writes with an error
   wire logic bad_acc   = ~hit_any | (pwrite & (hit_rh | hit_rl));
   wire logic lane0     = pstrb[0];
   wire logic wr_c0     = wr_take & hit_c0 & lane0;
   wire logic wr_c1     = wr_take & hit_c1 & lane0;
   wire logic wr_pf     = wr_take & hit_pf & lane0;
   wire logic wr_st     = wr_take & hit_st & lane0;
   wire logic wr_mk     = wr_take & hit_mk & lane0;

   // result alignment, unused bits zero
   wire logic [7:0] res_high = align ? {6'h00, result_r[9:8]}
                                     : result_r[9:2];
   wire logic [7:0] res_low  = align ? result_r[7:0]
                                     : {result_r[1:0], 6'h00};

   // busy is read back live in bit 6, not stored in the control byte
   wire logic [7:0] c0_view  = {control_0_r[7], busy_r, control_0_r[5:0]};

   wire logic [7:0] rd_mux   = hit_rh ? res_high :
                               hit_rl ? res_low :
                               hit_c0 ? c0_view :
                               hit_c1 ? control_1_r :
                               hit_pf ? {4'h0, pin_func_r} :
                               hit_st ? {7'h00, done_stat_r} :
                               hit_mk ? {7'h00, done_mask_r} : 8'h00;

   // bus answer: no wait state; read data is registered in the setup cycle so it leaves a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & bad_acc;
         prdata  <= (setup_ph & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // control registers; busy bit is not writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_0_r <= CONTROL_0_RST;
         control_1_r <= CONTROL_1_RST;
         pin_func_r  <= PIN_FUNC_RST;
      end else begin
         if (wr_c0)
            control_0_r <= pwdata[7:0];
         if (wr_c1)
            control_1_r <= pwdata[7:0];
         if (wr_pf)
            pin_func_r  <= pwdata[NUM_EXT-1:0];
      end
   end

   // ---------------- start detection ----------------
   // launch on the falling edge of the start bit after it was high;
   // a launch while busy or disabled is dropped
   wire logic launch = start_prev_r & ~start_bit & conv_en & ~busy_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         start_prev_r <= 1'b0;
      else
         start_prev_r <= start_bit;
   end

   // ---------------- converter clock ----------------
   // divider restarts at each launch so every trial is a full period
   wire logic [DIV_CNT_W-1:0] div_top = div_limit(div_sel);
   wire logic conv_tick = (div_cnt_r == div_top);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         div_cnt_r <= '0;
      else if (launch || conv_tick || state_r != ST_TRIAL)
         div_cnt_r <= '0;
      else
         div_cnt_r <= div_cnt_r + DIV_CNT_W'(1);
   end

   // ---------------- sequencer ----------------
   wire logic last_bit  = (bit_idx_r == 4'h0);
   wire logic keep_bit  = comp_hi;
   // disable aborts a conversion and leaves the old result alone
   wire logic abort     = ~conv_en;

   // one shared successive approximation engine for every source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= ST_IDLE;
         bit_idx_r <= 4'h0;
         code_r    <= RESULT_RST;
         busy_r    <= 1'b0;
         sample_r  <= 1'b0;
      end else begin
         sample_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (launch) begin
                  state_r   <= ST_TRIAL;
                  bit_idx_r <= 4'(RESULT_W - 1);
                  code_r    <= 10'h200;
                  busy_r    <= 1'b1;
               end
            end
            ST_TRIAL: begin
               if (abort) begin
                  state_r <= ST_IDLE;
                  busy_r  <= 1'b0;
               end else if (conv_tick) begin
                  sample_r <= 1'b1;
                  code_r[bit_idx_r] <= keep_bit;
                  if (last_bit) begin
                     state_r <= ST_DONE;
                  end else begin
                     code_r[bit_idx_r - 4'h1] <= 1'b1;
                     bit_idx_r <= bit_idx_r - 4'h1;
                  end
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
            default: begin
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   // whole 10-bit result written in one edge, never byte by byte
   wire logic finish = (state_r == ST_DONE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         result_r <= RESULT_RST;
      else if (finish && conv_en)
         result_r <= code_r;
   end

   // ---------------- interrupt ----------------
   // completion sets the sticky flag; set wins over a same-cycle clear
   wire logic done_evt = finish & conv_en;
   wire logic clr_done = wr_st & pwdata[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_stat_r <= 1'b0;
         done_mask_r <= 1'b0;
         irq         <= 1'b0;
      end else begin
         done_stat_r <= done_evt | (done_stat_r & ~clr_done);
         if (wr_mk)
            done_mask_r <= pwdata[0];
         irq <= done_stat_r & done_mask_r;
      end
   end

   // ---------------- analog routing ----------------
   wire adcr_src_e src_now  = src_decode(src_sel);
   // codes 4..15 name no pin, so the external path floats
   wire logic      ch_exist = (ch_sel < CH_W'(NUM_EXT));

   // routing outputs follow the control bytes one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_source    <= SRC_EXTERNAL;
         mux_ext_ch    <= 2'h0;
         mux_ext_valid <= 1'b0;
         vref_sel      <= 2'h0;
         conv_power_on <= 1'b0;
      end else begin
         mux_source    <= src_now;
         mux_ext_ch    <= ch_sel[1:0];
         mux_ext_valid <= ch_exist;
         vref_sel      <= vref_fld;
         conv_power_on <= conv_en;
      end
   end

   // trial code straight from the sequencer flop: with an undivided
   // converter clock the comparator must see the bit under trial at once
   assign sar_code   = code_r;
   assign sar_sample = sample_r;

   // ---------------- pin takeover ----------------
   // an analog pin drops its digital driver and its pull-high at once;
   // both outputs come from the same flop so they can never disagree
   assign pin_digital_off = pin_func_r;
   assign pin_pullup_off  = pin_func_r;

endmodule // adcr_top

// ---- tb/adcr_monitor.sv ----
// port checker for the converter register block
`timescale 1ns/1ns
module adcr_monitor
   import adcr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               sar_sample,
   input wire logic               conv_power_on,
   input wire logic [NUM_EXT-1:0] pin_digital_off,
   input wire logic [NUM_EXT-1:0] pin_pullup_off
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // bus answer timing, fixed single wait-free access
   ready_after_setup_a : assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_single_a : assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a : assert property (pslverr |-> pready)
      else $error("error without ready");
   // narrow registers: upper lanes always zero
   upper_zero_a : assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   // result pair refuses writes
   result_ro_a : assert property (psel && !penable && pwrite &&
      (paddr == ADDR_RESULT_HIGH || paddr == ADDR_RESULT_LOW) |=> pslverr) else $error("result write accepted");
   unmapped_err_a : assert property (psel && !penable && paddr > ADDR_IRQ_MASK
      |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   // analog pin drops digital function and pull-high together
   pin_pair_a : assert property (pin_digital_off == pin_pullup_off)
      else $error("pin function halves disagree");
   // pin takeover moves only on a completed bus write, never by itself
   pin_by_write_a : assert property ($changed(pin_digital_off) |-> $past(pready && pwrite))
      else $error("pin function changed without a write");
   off_no_sample_a : assert property (!conv_power_on && !$past(conv_power_on) |-> !sar_sample)
      else $error("trial while disabled");
endmodule // adcr_monitor

bind adcr_top adcr_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .sar_sample, .conv_power_on, .pin_digital_off, .pin_pullup_off);

// ---- tb/adcr_analog_model.sv ----
// behavioural analog front end answering the trial comparator
`timescale 1ns/1ns
module adcr_analog_model
   import adcr_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic [RESULT_W-1:0] sar_code,
   input  wire logic [1:0]          mux_source,
   input  wire logic [1:0]          mux_ext_ch,
   input  wire logic                mux_ext_valid,
   input  wire logic [RESULT_W-1:0] ext_ofs,
   output logic                     comp_hi
);
   logic [RESULT_W-1:0] vin;
   logic                wiggle_r = 1'b0;

   // floating input gives no stable answer
   always @(posedge pclk) wiggle_r <= ~wiggle_r;

   // level of the routed source
   always_comb begin
      case (mux_source)
         SRC_BANDGAP:  vin = 10'h2a5;
         SRC_LINE_AMP: vin = 10'h13c;
         SRC_GROUND:   vin = 10'h000;
         default:      vin = 10'h100 + 10'(mux_ext_ch) * 10'h055 + ext_ofs;
      endcase
   end

   // one shared comparator for every source
   assign comp_hi = (mux_source == SRC_EXTERNAL && !mux_ext_valid) ? wiggle_r : (vin >= sar_code);
endmodule // adcr_analog_model

// ---- tb/adcr_tb.sv ----
// self-checking bench for the converter register block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module tb;
   import adcr_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rdat, prdata;
   logic [3:0]  pstrb = 4'hf, pdo, ppo;
   logic        pready, pslverr, comp_hi, smp, pwr, vld, irq, rerr;
   logic [9:0]  code, v, ofs = 0;
   logic [1:0]  src, ch, vr;
   int          num_errors = 0, samples_checked = 0, cycles = 0, cyc;

   adcr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .comp_hi, .sar_code(code), .sar_sample(smp), .conv_power_on(pwr), .mux_source(src),
      .mux_ext_ch(ch), .mux_ext_valid(vld), .vref_sel(vr), .pin_digital_off(pdo), .pin_pullup_off(ppo), .irq);
   adcr_analog_model u_ana (.pclk, .sar_code(code), .mux_source(src), .mux_ext_ch(ch),
      .mux_ext_valid(vld), .ext_ofs(ofs), .comp_hi);

   // clock and hang guard
   initial forever #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end

   task print_verdict();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // source level as the far side presents it
   function automatic logic [9:0] exp_val(input int s, input int c);
      case (s)
         1: return 10'h2a5;
         2: return 10'h13c;
         3, 4: return 10'h000;
         default: return 10'h100 + 10'(c) * 10'h055;
      endcase
   endfunction

   // one whole transfer; released after the ready edge, then one idle edge
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // wait as long as the slave needs; only the cycle ceiling ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // both alignments read back live
   task chk_res(input logic [9:0] e, input logic [7:0] b);
      apb(1, ADDR_CONTROL_0, b);
      apb(0, ADDR_RESULT_HIGH, 0);
      `CHK(rdat, {24'h0, e[9:2]})
      apb(0, ADDR_RESULT_LOW, 0);
      `CHK(rdat, {24'h0, e[1:0], 6'h0})
      apb(1, ADDR_CONTROL_0, b | 8'h10);
      apb(0, ADDR_RESULT_HIGH, 0);
      `CHK(rdat, {30'h0, e[9:8]})
      apb(0, ADDR_RESULT_LOW, 0);
      `CHK(rdat, {24'h0, e[7:0]})
   endtask

   // start 0-1-0, then poll busy until it clears
   task conv(input logic [7:0] c0);
      logic seen;
      int   t0, n;
      apb(1, ADDR_CONTROL_0, c0 | 8'h80);
      apb(1, ADDR_CONTROL_0, c0);
      t0 = cycles;
      seen = 0;
      n = 0;
      do begin
         apb(0, ADDR_CONTROL_0, 0);
         seen |= rdat[6];
         n++;
      end while (rdat[6] !== 1'b0 && n < 600);
      cyc = cycles - t0;
      `CHK(seen, 1'b1)
      `CHK(rdat[6], 1'b0)
   endtask

   task t_reset();
      for (int a = 0; a < 16; a += 4) begin
         apb(0, 8'(a), 0);
         `CHK(rdat, 32'h0)
      end
      $display("reset values done");
   endtask

   task t_bus();
      apb(1, ADDR_RESULT_HIGH, 8'hff);
      `CHK(rerr, 1'b1)
      apb(0, 8'h1c, 0);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      pstrb <= 4'he;
      apb(1, ADDR_CONTROL_1, 8'h07);
      pstrb <= 4'hf;
      apb(0, ADDR_CONTROL_1, 0);
      `CHK(rdat, 32'h0)
      apb(1, ADDR_PIN_FUNC, 8'h05);
      @(posedge pclk);
      `CHK({pdo, ppo}, 8'h55)
      apb(1, ADDR_CONTROL_0, 8'h25);
      @(posedge pclk);
      `CHK(vld, 1'b0)
      apb(1, ADDR_CONTROL_0, 8'h23);
      @(posedge pclk);
      `CHK({vld, ch, src}, 5'b11100)
      $display("bus and pins done");
   endtask

   task t_src();
      for (int s = 0; s < 8; s++) begin
         apb(1, ADDR_CONTROL_1, 8'(s << 5));
         conv(8'h20 | 8'(s % 4));
         chk_res(exp_val(s, s % 4), 8'h20);
      end
      $display("sources done");
   endtask

   task t_div();
      for (int d = 0; d < 8; d++) begin
         apb(1, ADDR_CONTROL_1, 8'(d));
         conv(8'h20);
         `CHK(cyc >= (10 << d) && cyc <= (10 << d) + 16, 1'b1)
      end
      $display("dividers done");
   endtask

   // disabled start dropped, abort keeps the old result and no flag
   task t_hold();
      apb(1, ADDR_CONTROL_1, 0);
      conv(8'h21);
      v = exp_val(0, 1);
      ofs <= 10'h011;
      apb(1, ADDR_IRQ_STATUS, 8'h01);
      apb(1, ADDR_CONTROL_0, 8'h81);
      apb(1, ADDR_CONTROL_0, 8'h01);
      apb(0, ADDR_CONTROL_0, 0);
      `CHK(rdat[6], 1'b0)
      chk_res(v, 8'h00);
      apb(1, ADDR_CONTROL_1, 8'h07);
      apb(1, ADDR_CONTROL_0, 8'ha1);
      apb(1, ADDR_CONTROL_0, 8'h21);
      apb(1, ADDR_CONTROL_0, 8'h01);
      repeat (1300) @(posedge pclk);
      apb(0, ADDR_IRQ_STATUS, 0);
      `CHK({pwr, rdat[0]}, 2'b00)
      chk_res(v, 8'h00);
      ofs <= 10'h000;
      $display("retention done");
   endtask

   task t_irq();
      apb(1, ADDR_CONTROL_1, 0);
      apb(1, ADDR_IRQ_MASK, 8'h01);
      conv(8'h20);
      @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1, ADDR_IRQ_STATUS, 8'h01);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1, ADDR_IRQ_MASK, 8'h00);
      conv(8'h20);
      apb(0, ADDR_IRQ_STATUS, 0);
      `CHK({irq, rdat[0]}, 2'b01)
      $display("interrupt done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_bus();
      t_src();
      t_div();
      t_hold();
      t_irq();
      print_verdict();
   end
endmodule // tb
